// ### src/adc_ctrl_pkg.sv
// constants shared by the converter control block
package adc_ctrl_pkg;
   // ------------------------------------------------------------
   // register byte offsets (one 32-bit word each)
   // ------------------------------------------------------------
   localparam logic [7:0] cfg_off = 8'h00;
   localparam logic [7:0] ctrl_off = 8'h04;
   localparam logic [7:0] result_off = 8'h08;
   localparam logic [7:0] gt_limit_off = 8'h0c;
   localparam logic [7:0] lt_limit_off = 8'h10;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int cfg_div_lsb = 3;
   localparam int cfg_div_w = 5;
   localparam int cfg_eight_bit = 0;
   localparam int cfg_ljust = 2;
   localparam int ctrl_src_lsb = 0;
   localparam int ctrl_busy = 4;
   localparam int ctrl_done = 5;
   localparam int ctrl_win = 3;
   localparam int ctrl_t2_split = 6;
   // ------------------------------------------------------------
   // reset values and timing
   // ------------------------------------------------------------
   localparam logic [7:0] cfg_reset = 8'hf8;
   localparam logic [6:0] ctrl_reset = 7'h00;
   localparam logic [15:0] gt_reset = 16'hffff;
   localparam logic [15:0] lt_reset = 16'h0000;
   localparam logic [3:0] full_bits = 4'ha;
   localparam logic [3:0] short_bits = 4'h8;
   localparam logic [3:0] track_cycles = 4'h3;
   // ------------------------------------------------------------
   // start sources
   // ------------------------------------------------------------
   localparam logic [2:0] src_soft = 3'h0;
   localparam logic [2:0] src_timer0 = 3'h1;
   localparam logic [2:0] src_timer2 = 3'h2;
   localparam logic [2:0] src_timer1 = 3'h3;
   localparam logic [2:0] src_ext = 3'h4;
endpackage

// ### src/sar_clock_divider.sv
// enable pulse generator for the sar conversion clock
`timescale 1ns/1ps
module sar_clock_divider
   import adc_ctrl_pkg::*;
#(
   parameter int div_w = 5
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // control
   input wire logic run,
   input wire logic [div_w-1:0] divide,
   // enable out
   output logic tick
);
   if (div_w < 1 || div_w > 16) begin : g_bad_width
      $error("div_w out of range");
   end
   logic [div_w-1:0] count_reg;
   logic [div_w-1:0] count_next;
   logic tick_next;
   // ------------------------------------------------------------
   // divide by divide+1; restarts with each conversion
   // ------------------------------------------------------------
   always_comb begin
      count_next = count_reg;
      tick_next = 1'b0;
      if (!run) begin
         count_next = '0;
      end else if (count_reg >= divide) begin
         count_next = '0;
         tick_next = 1'b1;
      end else begin
         count_next = count_reg + 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count_reg <= '0;
         tick <= 1'b0;
      end else begin
         count_reg <= count_next;
         tick <= tick_next;
      end
   end
endmodule

// ### src/result_formatter.sv
// justifies the raw code and evaluates the window compare
`timescale 1ns/1ps
module result_formatter
   import adc_ctrl_pkg::*;
(
   // raw code and format
   input wire logic [9:0] code,
   input wire logic eight_bit,
   input wire logic left_justify,
   // limits
   input wire logic [15:0] gt_limit,
   input wire logic [15:0] lt_limit,
   // results
   output logic [15:0] word,
   output logic window_hit
);
   // ------------------------------------------------------------
   // formatting
   // ------------------------------------------------------------
   always_comb begin
      if (eight_bit) begin
         word = {code[9:2], 8'h00};
      end else if (left_justify) begin
         word = {code, 6'h00};
      end else begin
         word = {6'h00, code};
      end
   end
   // ------------------------------------------------------------
   // window compare; limits already written in the chosen format
   // ------------------------------------------------------------
   always_comb begin
      if (lt_limit > gt_limit) begin
         window_hit = (word > gt_limit) && (word < lt_limit);
      end else begin
         window_hit = (word < gt_limit) || (word > lt_limit);
      end
   end
endmodule

// ### src/adc_conversion_control.sv
// converter control: triggers, busy and done handshake, result, window flag
// Functional notes
// - result is a 10-bit unsigned code in high and low bytes, updated per conversion
// - justify select 0 gives right-justified, 1 gives left-justified code
// - result bits not carrying code read as zero
// - eight-bit mode keeps 8 msbs in the high byte, justify ignored
// - eight-bit conversion ends two sar clocks sooner
// - sar clock is system clock divided by the divider field plus one
// - start source field picks software, timer 0, 2, 1 or external edge
// - software writing 1 to in-progress bit starts one conversion
// - in-progress bit is 1 during conversion, 0 when finished
// - falling edge of in-progress sets done flag and requests interrupt
// - result valid whenever done flag is 1; poll done, not busy
// - timer 2 uses low-byte overflow in 8-bit mode, else high-byte
// - inside window: result above greater-than and below less-than limit
// - outside window: result below greater-than or above less-than limit
// - external start input also drives the current-output update trigger
`timescale 1ns/1ps
module adc_conversion_control
   import adc_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // triggers
   input wire logic timer0_overflow,
   input wire logic timer1_overflow,
   input wire logic timer2_low_overflow,
   input wire logic timer2_high_overflow,
   input wire logic external_start_input,
   // analog sar core
   input wire logic sar_compare,
   output logic sar_sample,
   output logic [9:0] sar_trial,
   // system side
   output logic conversion_irq,
   output logic current_output_update
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      st_idle = 3'b001,
      st_track = 3'b010,
      st_convert = 3'b100
   } conv_state_e;

   conv_state_e state_reg, state_next;
   logic [7:0] converter_config_register, cfg_next;
   logic [2:0] start_source_select, src_next;
   logic timer2_split_reg, timer2_split_next;
   logic conversion_in_progress;
   logic conversion_done_flag, done_next;
   logic window_match_flag, win_next;
   logic [15:0] gt_reg, gt_next;
   logic [15:0] lt_reg, lt_next;
   logic [15:0] result_reg, result_next;
   logic [9:0] sar_reg, sar_next;
   logic [3:0] bit_reg, bit_next;
   logic [3:0] track_reg, track_next;
   logic [3:0] off_reg, off_next;
   logic wb_ack_next;
   logic [31:0] wb_dat_next;
   logic irq_next;
   logic ext_meta_reg, ext_sync_reg, ext_prev_reg;
   logic upd_next;
   logic sar_tick;
   logic [15:0] fmt_word;
   logic fmt_hit;
   logic start_event;
   logic finish;
   logic bus_req, wr_ctrl;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] nw,
                                       input logic en);
      lane = en ? nw : old;
   endfunction

   // the ack itself masks the request, so one strobe is taken only once
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_ctrl = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == ctrl_off);
   assign conversion_in_progress = (state_reg != st_idle);

   // ------------------------------------------------------------
   // external start pin: two flops before the edge detector
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ext_meta_reg <= 1'b0;
         ext_sync_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
      end else begin
         ext_meta_reg <= external_start_input;
         ext_sync_reg <= ext_meta_reg;
         ext_prev_reg <= ext_sync_reg;
      end
   end

   // ------------------------------------------------------------
   // trigger selection
   // ------------------------------------------------------------
   always_comb begin
      case (start_source_select)
         src_soft: start_event = wr_ctrl && wb_dat_i[ctrl_busy];
         src_timer0: start_event = timer0_overflow;
         src_timer2: start_event = timer2_split_reg ? timer2_low_overflow
                                                    : timer2_high_overflow;
         src_timer1: start_event = timer1_overflow;
         src_ext: start_event = ext_sync_reg && !ext_prev_reg;
         default: start_event = 1'b0;
      endcase
   end
   // the same edge also updates the current-output converter
   assign upd_next = ext_sync_reg && !ext_prev_reg;

   // ------------------------------------------------------------
   // sar clock and formatting
   // ------------------------------------------------------------
   sar_clock_divider #(
      .div_w(cfg_div_w)
   ) u_div (
      .clk(clk),
      .rst_b(rst_b),
      .run(conversion_in_progress),
      .divide(converter_config_register[cfg_div_lsb +: cfg_div_w]),
      .tick(sar_tick)
   );

   result_formatter u_fmt (
      .code(sar_next),
      .eight_bit(converter_config_register[cfg_eight_bit]),
      .left_justify(converter_config_register[cfg_ljust]),
      .gt_limit(gt_reg),
      .lt_limit(lt_reg),
      .word(fmt_word),
      .window_hit(fmt_hit)
   );

   // ------------------------------------------------------------
   // conversion sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      sar_next = sar_reg;
      bit_next = bit_reg;
      track_next = track_reg;
      off_next = off_reg;
      finish = 1'b0;
      case (state_reg)
         st_idle: begin
            // triggers during a conversion are ignored
            if (start_event) begin
               state_next = st_track;
               track_next = '0;
            end
         end
         st_track: begin
            if (sar_tick) begin
               if (track_reg == track_cycles - 4'h1) begin
                  state_next = st_convert;
                  sar_next = 10'h200;
                  bit_next = converter_config_register[cfg_eight_bit] ? short_bits
                                                                      : full_bits;
                  // latched with the count so a config write mid-run cannot skew it
                  off_next = converter_config_register[cfg_eight_bit] ? full_bits - short_bits
                                                                      : 4'h0;
               end else begin
                  track_next = track_reg + 4'h1;
               end
            end
         end
         st_convert: begin
            if (sar_tick) begin
               // an eight-bit run counts 8 down to 1 but still works on the top bits
               if (!sar_compare) begin
                  sar_next[bit_reg - 4'h1 + off_reg] = 1'b0;
               end
               if (bit_reg == 4'h1) begin
                  state_next = st_idle;
                  finish = 1'b1;
               end else begin
                  sar_next[bit_reg - 4'h2 + off_reg] = 1'b1;
                  bit_next = bit_reg - 4'h1;
               end
            end
         end
         default: state_next = st_idle;
      endcase
   end

   // ------------------------------------------------------------
   // register file and flags
   // ------------------------------------------------------------
   always_comb begin
      cfg_next = converter_config_register;
      src_next = start_source_select;
      timer2_split_next = timer2_split_reg;
      gt_next = gt_reg;
      lt_next = lt_reg;
      done_next = conversion_done_flag;
      win_next = window_match_flag;
      result_next = result_reg;
      wb_ack_next = bus_req;
      wb_dat_next = 32'h0000_0000;
      if (bus_req && wb_we_i) begin
         if (wb_adr_i == cfg_off) begin
            cfg_next = lane(converter_config_register, wb_dat_i[7:0], wb_sel_i[0]);
         end else if (wb_adr_i == ctrl_off && wb_sel_i[0]) begin
            src_next = wb_dat_i[ctrl_src_lsb +: 3];
            timer2_split_next = wb_dat_i[ctrl_t2_split];
            if (!wb_dat_i[ctrl_done]) done_next = 1'b0;
            if (!wb_dat_i[ctrl_win]) win_next = 1'b0;
         end else if (wb_adr_i == gt_limit_off) begin
            gt_next = {lane(gt_reg[15:8], wb_dat_i[15:8], wb_sel_i[1]),
                       lane(gt_reg[7:0], wb_dat_i[7:0], wb_sel_i[0])};
         end else if (wb_adr_i == lt_limit_off) begin
            lt_next = {lane(lt_reg[15:8], wb_dat_i[15:8], wb_sel_i[1]),
                       lane(lt_reg[7:0], wb_dat_i[7:0], wb_sel_i[0])};
         end
      end else if (bus_req) begin
         if (wb_adr_i == cfg_off) begin
            wb_dat_next = {24'h000000, converter_config_register};
         end else if (wb_adr_i == ctrl_off) begin
            wb_dat_next = {25'h0000000, timer2_split_reg, conversion_done_flag,
                           conversion_in_progress, window_match_flag, start_source_select};
         end else if (wb_adr_i == result_off) begin
            wb_dat_next = {16'h0000, result_reg};
         end else if (wb_adr_i == gt_limit_off) begin
            wb_dat_next = {16'h0000, gt_reg};
         end else if (wb_adr_i == lt_limit_off) begin
            wb_dat_next = {16'h0000, lt_reg};
         end
      end
      // hardware set wins over a same-cycle software clear
      if (finish) begin
         result_next = fmt_word;
         done_next = 1'b1;
         if (fmt_hit) win_next = 1'b1;
      end
   end
   assign irq_next = finish;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= st_idle;
         sar_reg <= '0;
         bit_reg <= '0;
         track_reg <= '0;
         off_reg <= '0;
         converter_config_register <= cfg_reset;
         start_source_select <= ctrl_reset[2:0];
         timer2_split_reg <= 1'b0;
         conversion_done_flag <= 1'b0;
         window_match_flag <= 1'b0;
         gt_reg <= gt_reset;
         lt_reg <= lt_reset;
         result_reg <= '0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
         conversion_irq <= 1'b0;
         current_output_update <= 1'b0;
         sar_sample <= 1'b0;
         sar_trial <= '0;
      end else begin
         state_reg <= state_next;
         sar_reg <= sar_next;
         bit_reg <= bit_next;
         track_reg <= track_next;
         off_reg <= off_next;
         converter_config_register <= cfg_next;
         start_source_select <= src_next;
         timer2_split_reg <= timer2_split_next;
         conversion_done_flag <= done_next;
         window_match_flag <= win_next;
         gt_reg <= gt_next;
         lt_reg <= lt_next;
         result_reg <= result_next;
         wb_ack_o <= wb_ack_next;
         wb_dat_o <= wb_dat_next;
         conversion_irq <= irq_next;
         current_output_update <= upd_next;
         sar_sample <= (state_next == st_track);
         sar_trial <= sar_next;
      end
   end
endmodule

// ### verification/adc_conversion_control_assertions.sv
// port checker for the converter control block
`timescale 1ns/1ps
module adc_conversion_control_assertions
   import adc_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // pins and events
   input wire logic external_start_input,
   input wire logic conversion_irq,
   input wire logic current_output_update
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   property p_ack_once;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
   property p_ack_answer;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
   property p_dat_idle;
      !wb_ack_o |-> wb_dat_o == 32'h0;
   endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
   property p_unmapped;
      wb_ack_o && !wb_we_i && wb_adr_i > lt_limit_off |-> wb_dat_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_upper_zero;
      wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("unused bits set");
   property p_irq_single;
      conversion_irq |=> !conversion_irq [*8];
   endproperty
   a_irq_single: assert property (p_irq_single) else $error("irq too close");
   property p_update_follow;
      $rose(external_start_input) |-> ##[1:4] current_output_update;
   endproperty
   a_update_follow: assert property (p_update_follow) else $error("no update pulse");
   property p_update_single;
      current_output_update |=> !current_output_update;
   endproperty
   a_update_single: assert property (p_update_single) else $error("update too long");
   c_irq: cover property (conversion_irq);
   c_update: cover property (current_output_update);
   c_unmapped: cover property (wb_ack_o && !wb_we_i && wb_adr_i > lt_limit_off);
endmodule

// ### verification/adc_trigger_partner.sv
// timers, start pin and comparator seen from the converter
`timescale 1ns/1ps
module adc_trigger_partner (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // bench control
   input wire logic [9:0] target,
   input wire logic [4:0] pulse_req,
   // to the converter
   input wire logic [9:0] sar_trial,
   output logic sar_compare,
   output logic timer0_overflow,
   output logic timer1_overflow,
   output logic timer2_low_overflow,
   output logic timer2_high_overflow,
   output logic external_start_input
);
   logic [2:0] hold_reg;
   // ideal comparator: keeps the trial bit while the input is not below it
   assign sar_compare = (sar_trial <= target);
   // pin held high a few cycles so the two-flop sync sees it; idles low
   assign external_start_input = (hold_reg != 3'h0);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         {timer2_high_overflow, timer2_low_overflow, timer1_overflow, timer0_overflow} <= 4'h0;
         hold_reg <= 3'h0;
      end else begin
         {timer2_high_overflow, timer2_low_overflow, timer1_overflow, timer0_overflow} <=
            pulse_req[3:0];
         hold_reg <= pulse_req[4] ? 3'h4 : hold_reg - {2'h0, hold_reg != 3'h0};
      end
   end
endmodule

// ### verification/tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top;
   import adc_ctrl_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h0;
   logic [31:0] wdat = 32'h0, dat_o, q;
   logic [9:0] tgt = 10'h0, trial;
   logic [4:0] req = 5'h0;
   logic ack, t0, t1, t2l, t2h, ext, cmp, sample, irq, upd;
   int bad_count = 0, checks_done = 0, cyc_n = 0, irq_n = 0, upd_n = 0, smp_n = 0, u;
   time t_start, irq_t, d10a, d8, d10b;
   logic [7:0] ra [6] = '{cfg_off, ctrl_off, result_off, gt_limit_off, lt_limit_off, 8'h14};
   logic [31:0] rv [6] = '{32'(cfg_reset), 32'h0, 32'h0, 32'(gt_reset), 32'(lt_reset), 32'h0};
   logic [7:0] tcv [5] = '{8'h01, 8'h02, 8'h42, 8'h03, 8'h04};
   logic [4:0] tgood [5] = '{5'h01, 5'h08, 5'h04, 5'h02, 5'h10};
   logic [4:0] tbad [5] = '{5'h02, 5'h04, 5'h08, 5'h01, 5'h01};
   logic [7:0] wcfg [9] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h4, 8'h4};
   logic [15:0] wgt [9] = '{16'h40, 16'h40, 16'h40, 16'h40, 16'h80, 16'h80, 16'h80, 16'h1000, 16'h1000};
   logic [15:0] wlt [9] = '{16'h80, 16'h80, 16'h80, 16'h80, 16'h80, 16'h80, 16'h80, 16'h2000, 16'h2000};
   logic [9:0] wt [9] = '{10'h40, 10'h80, 10'h41, 10'h7f, 10'h80, 10'h7f, 10'h81, 10'h40, 10'h41};
   logic whit [9] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
   always #5 clk = ~clk;
   adc_conversion_control adc_conversion_control_i (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .timer0_overflow(t0), .timer1_overflow(t1),
      .timer2_low_overflow(t2l), .timer2_high_overflow(t2h), .external_start_input(ext),
      .sar_compare(cmp), .sar_sample(sample), .sar_trial(trial), .conversion_irq(irq),
      .current_output_update(upd));
   adc_trigger_partner adc_trigger_partner_i (.clk(clk), .rst_b(rst_b), .target(tgt),
      .pulse_req(req), .sar_trial(trial), .sar_compare(cmp), .timer0_overflow(t0),
      .timer1_overflow(t1), .timer2_low_overflow(t2l), .timer2_high_overflow(t2h),
      .external_start_input(ext));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic wrap_up;
      $display("mismatches %0d comparisons %0d", bad_count, checks_done);
      if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc_n++;
      if (irq === 1'b1) begin
         irq_n++;
         irq_t = $time;
      end
      if (upd === 1'b1) upd_n++;
      if (sample === 1'b1) smp_n++;
      if (cyc_n == 60000) begin
         bad_count++;
         wrap_up;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // request held until the edge that sees ack, released right after it
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = dat_o;
      chk({31'h0, ack}, 32'h1);
      {cyc, stb, we} <= 3'h0;
   endtask
   task automatic fire(input logic [4:0] b);
      @(posedge clk) req <= b;
      @(posedge clk) req <= 5'h0;
   endtask
   task automatic conv(input logic [9:0] t, input logic [7:0] cv, input logic [4:0] b);
      int n, k, s;
      n = irq_n;
      s = smp_n;
      k = 0;
      tgt <= t;
      wb(1'b1, ctrl_off, {24'h0, cv});
      t_start = $time;
      if (b != 5'h0) fire(b);
      q = 32'h0;
      while (q[ctrl_done] !== 1'b1 && k < 100) begin
         wb(1'b0, ctrl_off, 32'h0);
         k++;
      end
      chk({31'h0, q[ctrl_busy]}, 32'h0);
      repeat (2) @(posedge clk);
      chk(irq_n - n, 32'h1);
      chk({31'h0, smp_n != s}, 32'h1);
      chk({31'h0, sample}, 32'h0);
      wb(1'b0, result_off, 32'h0);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         wb(1'b0, ra[i], 32'h0);
         chk(q, rv[i]);
      end
      wb(1'b1, cfg_off, 32'h0);
      conv(10'h3ff, 8'h10, 5'h0);
      chk(q, 32'h3ff);
      wb(1'b1, cfg_off, 32'h4);
      conv(10'h3ff, 8'h10, 5'h0);
      chk(q, 32'hffc0);
      conv(10'h200, 8'h10, 5'h0);
      chk(q, 32'h8000);
      wb(1'b1, cfg_off, 32'h5);
      conv(10'h2a5, 8'h10, 5'h0);
      chk(q, 32'ha900);
      // period of the sar clock scales with the divider field
      wb(1'b1, cfg_off, 32'h8);
      conv(10'h155, 8'h10, 5'h0);
      d10a = irq_t - t_start;
      wb(1'b1, cfg_off, 32'h9);
      conv(10'h155, 8'h10, 5'h0);
      d8 = irq_t - t_start;
      wb(1'b1, cfg_off, 32'h18);
      conv(10'h155, 8'h10, 5'h0);
      d10b = irq_t - t_start;
      chk(32'(d10a - d8), 32'h28);
      chk(32'(d10b - d10a), 32'h104);
      wb(1'b1, cfg_off, 32'h0);
      for (int i = 0; i < 5; i++) begin
         u = upd_n;
         wb(1'b1, ctrl_off, {24'h0, tcv[i]});
         fire(tbad[i]);
         repeat (40) @(posedge clk);
         wb(1'b0, ctrl_off, 32'h0);
         chk({31'h0, q[ctrl_done]}, 32'h0);
         conv(10'h2aa, tcv[i], tgood[i]);
         chk(q, 32'h2aa);
         chk(upd_n - u, (i == 4) ? 32'h1 : 32'h0);
      end
      wb(1'b1, ctrl_off, 32'h0);
      for (int i = 0; i < 9; i++) begin
         wb(1'b1, cfg_off, {24'h0, wcfg[i]});
         wb(1'b1, gt_limit_off, {16'h0, wgt[i]});
         wb(1'b1, lt_limit_off, {16'h0, wlt[i]});
         conv(wt[i], 8'h10, 5'h0);
         wb(1'b0, ctrl_off, 32'h0);
         chk({31'h0, q[ctrl_win]}, {31'h0, whit[i]});
      end
      repeat (20) @(posedge clk);
      wb(1'b0, ctrl_off, 32'h0);
      chk({30'h0, q[ctrl_done], q[ctrl_win]}, 32'h3);
      wb(1'b1, ctrl_off, 32'h28);
      wb(1'b0, ctrl_off, 32'h0);
      chk({30'h0, q[ctrl_done], q[ctrl_win]}, 32'h3);
      wb(1'b1, ctrl_off, 32'h0);
      wb(1'b0, ctrl_off, 32'h0);
      chk({30'h0, q[ctrl_done], q[ctrl_win]}, 32'h0);
      wrap_up;
   end
endmodule
bind adc_conversion_control adc_conversion_control_assertions adc_conversion_control_assertions_i (
   .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .external_start_input(external_start_input), .conversion_irq(conversion_irq),
   .current_output_update(current_output_update));
